// ===== hdl/load_store_shift_unit.sv
`default_nettype none
module load_store_shift_unit (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Instruction sequencer
  input  wire logic        start,
  input  wire logic [23:0] instr,
  output logic             busy,
  output logic             done,
  output logic             skip,
  output logic             illegal,
  // Architectural registers
  output logic [23:0]      acc,
  output logic [23:0]      aux,
  output logic [14:0]      index1,
  output logic [14:0]      index2,
  output logic [14:0]      index3,
  // Core storage
  output logic             memReq,
  output logic             memWe,
  output logic [14:0]      memAddr,
  output logic [23:0]      memWdata,
  input  wire logic [23:0] memRdata,
  input  wire logic        memAck
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_INDIR  = 3'b001,
    S_READ1  = 3'b010,
    S_READ2  = 3'b011,
    S_WRITE1 = 3'b100,
    S_WRITE2 = 3'b101,
    S_DONE   = 3'b110
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [5:0]  op;
    logic [1:0]  bsel;
    logic [14:0] ea;
    logic [1:0]  chpos;
    logic [23:0] word;
    logic        issued;
    logic [23:0] acc;
    logic [23:0] aux;
    logic [14:0] idx1;
    logic [14:0] idx2;
    logic [14:0] idx3;
    logic        done;
    logic        skip;
    logic        illegal;
  } unit_t;
  unit_t st, next_st;

  lssu_mem_if mif ();

  lssu_mem_port u_port (
    .clock    (clock),
    .srst     (srst),
    .mif      (mif.port),
    .memReq   (memReq),
    .memWe    (memWe),
    .memAddr  (memAddr),
    .memWdata (memWdata),
    .memRdata (memRdata),
    .memAck   (memAck)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [14:0] oc_inc(input logic [14:0] a);
    logic [15:0] s;
    s = {1'b0, a} + 16'h0001;
    oc_inc = s[14:0] + {14'h0000, s[15]};
  endfunction

  function automatic logic [14:0] pick_idx(input unit_t s, input logic [1:0] b);
    pick_idx = (b == 2'h1) ? s.idx1 : (b == 2'h2) ? s.idx2 : (b == 2'h3) ? s.idx3 : 15'h0000;
  endfunction

  function automatic logic [23:0] put_char(input logic [23:0] w, input logic [1:0] p,
                                           input logic [5:0] c);
    logic [23:0] r;
    r = w;
    unique case (p)
      2'h0: r[23:18] = c;
      2'h1: r[17:12] = c;
      2'h2: r[11:6]  = c;
      2'h3: r[5:0]   = c;
    endcase
    put_char = r;
  endfunction

  function automatic logic [5:0] get_char(input logic [23:0] w, input logic [1:0] p);
    get_char = w[23 - 6 * p -: 6];
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [5:0]  dOp;
  logic        dInd;
  logic [1:0]  dB;
  logic [14:0] dAddr;
  logic [16:0] dChar;
  logic        dIsChar;
  logic        dNoIdx;
  logic [14:0] dIdx;
  logic [14:0] selIdx;
  logic [16:0] charAddr;
  logic [14:0] wordAddr;
  logic [23:0] shiftCount;
  logic [5:0]  shiftMag;
  logic [23:0] shiftSrc;
  logic [23:0] shiftOut;
  logic        knownOp;

  always_comb begin
    dOp     = instr[lssu_pkg::OPC_HI:lssu_pkg::OPC_LO];
    dInd    = instr[lssu_pkg::AMODE_BIT];
    dB      = instr[lssu_pkg::IDX_HI:lssu_pkg::IDX_LO];
    dAddr   = instr[lssu_pkg::ADDR_HI:0];
    dChar   = instr[16:0];
    dIsChar = (dOp == lssu_pkg::OP_LOAD_ACC_CHAR) || (dOp == lssu_pkg::OP_LOAD_AUX_CHAR) ||
              (dOp == lssu_pkg::OP_STORE_ACC_CHAR) || (dOp == lssu_pkg::OP_STORE_AUX_CHAR);
    dNoIdx  = (dOp == lssu_pkg::OP_LOAD_INDEX) || (dOp == lssu_pkg::OP_STORE_INDEX) ||
              (dOp == lssu_pkg::OP_SENSE_ROTATE);
    // Character ops: bit 15 selects indexing; which index depends on opcode
    dIdx = 15'h0000;
    if (dIsChar && instr[15]) begin
      dIdx = ((dOp == lssu_pkg::OP_LOAD_ACC_CHAR) || (dOp == lssu_pkg::OP_STORE_AUX_CHAR))
             ? st.idx1 : st.idx2;
    end
    charAddr = dChar + {{2{dIdx[14]}}, dIdx};
    selIdx   = pick_idx(st, dB);
    wordAddr = dNoIdx ? dAddr : dAddr + selIdx;
    knownOp  = dIsChar || dNoIdx || (dOp == lssu_pkg::OP_SHIFT_REG) ||
               (dOp[5:3] == 3'b010) || ((dOp[5:3] == 3'b100) && (dOp != lssu_pkg::OP_STORE_INDEX));
    // Shift amount from sign-extended k plus sign-extended index
    shiftCount = {{9{dAddr[14]}}, dAddr} +
                 {{9{selIdx[14]}}, selIdx};
    shiftMag   = shiftCount[lssu_pkg::SIGN_BIT] ? ~shiftCount[5:0] : shiftCount[5:0];
    shiftSrc   = dInd ? st.aux : st.acc;
    if (!shiftCount[lssu_pkg::SIGN_BIT]) begin
      shiftOut = 24'(({shiftSrc, shiftSrc} << (shiftMag % 6'd24)) >> 24);
    end else if (shiftMag >= 6'(lssu_pkg::RIGHT_FILL_COUNT)) begin
      shiftOut = {24{shiftSrc[23]}};
    end else begin
      shiftOut = 24'($signed(shiftSrc) >>> shiftMag);
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.done    = 1'b0;
    // Skip and illegal must survive the write-back phases up to the done pulse
    mif.req   = 1'b0;
    mif.we    = 1'b0;
    mif.addr  = st.ea;
    mif.wdata = st.word;
    unique case (st.phase)
      S_IDLE: begin
        next_st.issued  = 1'b0;
        next_st.skip    = 1'b0;
        next_st.illegal = 1'b0;
        if (start) begin
          next_st.op    = dOp;
          next_st.bsel  = dB;
          next_st.phase = S_READ1;
          next_st.ea    = dIsChar ? charAddr[16:2] : wordAddr;
          next_st.chpos = charAddr[1:0];
          if (!knownOp) begin
            next_st.illegal = 1'b1;
            next_st.phase   = S_DONE;
          end else if (dOp == lssu_pkg::OP_SHIFT_REG) begin
            if (dInd) next_st.aux = shiftOut;
            else next_st.acc = shiftOut;
            next_st.phase = S_DONE;
          end else if (dInd && !dIsChar && dOp != lssu_pkg::OP_SENSE_ROTATE) begin
            next_st.phase = S_INDIR;
          end
        end
      end
      S_INDIR: begin
        mif.req = !st.issued;
        next_st.issued = 1'b1;
        if (mif.done) begin
          next_st.issued = 1'b0;
          // Index fields of the chain are ignored for index load and store
          if (st.op == lssu_pkg::OP_LOAD_INDEX || st.op == lssu_pkg::OP_STORE_INDEX) begin
            next_st.ea = mif.rdata[14:0];
          end else begin
            next_st.ea = mif.rdata[14:0] + pick_idx(st, mif.rdata[16:15]);
          end
          if (!mif.rdata[lssu_pkg::AMODE_BIT]) next_st.phase = S_READ1;
        end
      end
      S_READ1: begin
        if (st.op == lssu_pkg::OP_STORE_ACC || st.op == lssu_pkg::OP_STORE_AUX ||
            st.op == lssu_pkg::OP_STORE_PAIR) begin
          next_st.word  = (st.op == lssu_pkg::OP_STORE_AUX) ? st.aux : st.acc;
          next_st.phase = S_WRITE1;
        end else begin
          mif.req = !st.issued;
          next_st.issued = 1'b1;
          if (mif.done) begin
            next_st.issued = 1'b0;
            next_st.phase  = S_DONE;
            next_st.word   = mif.rdata;
            unique case (st.op)
              lssu_pkg::OP_LOAD_ACC:      next_st.acc = mif.rdata;
              lssu_pkg::OP_LOAD_AUX:      next_st.aux = mif.rdata;
              lssu_pkg::OP_LOAD_ACC_COMP: next_st.acc = ~mif.rdata;
              lssu_pkg::OP_LOAD_LOGICAL:  next_st.acc = st.aux & mif.rdata;
              lssu_pkg::OP_LOAD_ACC_CHAR:
                next_st.acc = {18'h00000, get_char(mif.rdata, st.chpos)};
              lssu_pkg::OP_LOAD_AUX_CHAR:
                next_st.aux = {18'h00000, get_char(mif.rdata, st.chpos)};
              lssu_pkg::OP_LOAD_PAIR: begin
                next_st.acc = mif.rdata;
                next_st.phase = S_READ2;
              end
              lssu_pkg::OP_LOAD_PAIR_COMP: begin
                next_st.acc = ~mif.rdata;
                next_st.phase = S_READ2;
              end
              lssu_pkg::OP_LOAD_INDEX: begin
                if (st.bsel == 2'h1) next_st.idx1 = mif.rdata[14:0];
                if (st.bsel == 2'h2) next_st.idx2 = mif.rdata[14:0];
                if (st.bsel == 2'h3) next_st.idx3 = mif.rdata[14:0];
              end
              lssu_pkg::OP_STORE_ACC_CHAR: begin
                next_st.word  = put_char(mif.rdata, st.chpos, st.acc[5:0]);
                next_st.phase = S_WRITE1;
              end
              lssu_pkg::OP_STORE_AUX_CHAR: begin
                next_st.word  = put_char(mif.rdata, st.chpos, st.aux[5:0]);
                next_st.phase = S_WRITE1;
              end
              lssu_pkg::OP_STORE_INDEX: begin
                next_st.word  = {mif.rdata[23:15], pick_idx(st, st.bsel)};
                next_st.phase = S_WRITE1;
              end
              lssu_pkg::OP_STORE_WORD_ADR: begin
                next_st.word  = {mif.rdata[23:15], st.acc[14:0]};
                next_st.phase = S_WRITE1;
              end
              lssu_pkg::OP_STORE_CHAR_ADR: begin
                next_st.word  = {mif.rdata[23:17], st.acc[16:0]};
                next_st.phase = S_WRITE1;
              end
              lssu_pkg::OP_SENSE_ROTATE: begin
                next_st.skip  = mif.rdata[lssu_pkg::SIGN_BIT];
                next_st.word  = {mif.rdata[22:0], mif.rdata[23]};
                next_st.phase = S_WRITE1;
              end
              default: next_st.phase = S_DONE;
            endcase
          end
        end
      end
      S_READ2: begin
        mif.req  = !st.issued;
        mif.addr = oc_inc(st.ea);
        next_st.issued = 1'b1;
        if (mif.done) begin
          next_st.issued = 1'b0;
          next_st.aux = (st.op == lssu_pkg::OP_LOAD_PAIR_COMP) ? ~mif.rdata : mif.rdata;
          next_st.phase = S_DONE;
        end
      end
      S_WRITE1: begin
        mif.req = !st.issued;
        mif.we  = 1'b1;
        next_st.issued = 1'b1;
        if (mif.done) begin
          next_st.issued = 1'b0;
          next_st.phase  = (st.op == lssu_pkg::OP_STORE_PAIR) ? S_WRITE2 : S_DONE;
        end
      end
      S_WRITE2: begin
        mif.req   = !st.issued;
        mif.we    = 1'b1;
        mif.addr  = oc_inc(st.ea);
        mif.wdata = st.aux;
        next_st.issued = 1'b1;
        if (mif.done) begin
          next_st.issued = 1'b0;
          next_st.phase  = S_DONE;
        end
      end
      S_DONE: begin
        next_st.done  = 1'b1;
        next_st.skip  = st.skip;
        next_st.phase = S_IDLE;
      end
      default: next_st.phase = S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign busy    = (st.phase != S_IDLE);
  assign done    = st.done;
  assign skip    = st.done & st.skip;
  assign illegal = st.done & st.illegal;
  assign acc     = st.acc;
  assign aux     = st.aux;
  assign index1  = st.idx1;
  assign index2  = st.idx2;
  assign index3  = st.idx3;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_pair_second_addr;
    @(posedge clock) disable iff (srst)
      (memReq && !$past(memReq) && st.phase == S_READ2) |-> memAddr == oc_inc(st.ea);
  endproperty
  a_pair_second_addr: assert property (p_pair_second_addr) else $error("pair addr");

  property p_store_keeps_acc;
    @(posedge clock) disable iff (srst)
      (st.phase == S_WRITE1) |=> acc == $past(acc);
  endproperty
  a_store_keeps_acc: assert property (p_store_keeps_acc) else $error("acc changed");

  property p_rotate_wb;
    @(posedge clock) disable iff (srst)
      (st.phase == S_READ1 && st.op == lssu_pkg::OP_SENSE_ROTATE && mif.done) |=>
        st.word == {$past(mif.rdata[22:0]), $past(mif.rdata[23])};
  endproperty
  a_rotate_wb: assert property (p_rotate_wb) else $error("rotate wrong");

  property p_char_clear;
    @(posedge clock) disable iff (srst)
      (st.phase == S_READ1 && st.op == lssu_pkg::OP_LOAD_ACC_CHAR && mif.done) |=>
        acc[23:6] == 18'h00000;
  endproperty
  a_char_clear: assert property (p_char_clear) else $error("char not clear");

  property p_load_acc;
    @(posedge clock) disable iff (srst)
      (st.phase == S_READ1 && st.op == lssu_pkg::OP_LOAD_ACC && mif.done) |=>
        acc == $past(mif.rdata);
  endproperty
  a_load_acc: assert property (p_load_acc) else $error("load wrong");

  property p_done_pulse;
    @(posedge clock) disable iff (srst)
      done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held");

  property p_swa_keep;
    @(posedge clock) disable iff (srst)
      (memReq && memWe && st.op == lssu_pkg::OP_STORE_WORD_ADR) |->
        memWdata[14:0] == acc[14:0];
  endproperty
  a_swa_keep: assert property (p_swa_keep) else $error("word addr field");

  property p_shift_one_cycle;
    @(posedge clock) disable iff (srst)
      (start && !busy && instr[23:18] == lssu_pkg::OP_SHIFT_REG) |=> ##1 done;
  endproperty
  a_shift_one_cycle: assert property (p_shift_one_cycle) else $error("shift late");
endmodule // load_store_shift_unit
`default_nettype wire

// ===== hdl/lssu_mem_if.sv
`default_nettype none
// ----------------------------------------------------------------------
// Core storage request carrier between sequencer and store port
// ----------------------------------------------------------------------
interface lssu_mem_if;
  logic        req;
  logic        we;
  logic [14:0] addr;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic        done;
  modport ctrl (output req, output we, output addr, output wdata,
                input rdata, input done);
  modport port (input req, input we, input addr, input wdata,
                output rdata, output done);
endinterface
`default_nettype wire

// ===== hdl/lssu_mem_port.sv
`default_nettype none
// ----------------------------------------------------------------------
// Registered store port: one request outstanding at a time
// ----------------------------------------------------------------------
module lssu_mem_port (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Internal side
  lssu_mem_if.port         mif,
  // Core storage pins
  output logic             memReq,
  output logic             memWe,
  output logic [14:0]      memAddr,
  output logic [23:0]      memWdata,
  input  wire logic [23:0] memRdata,
  input  wire logic        memAck
);
  typedef struct packed {
    logic        busy;
    logic        we;
    logic [14:0] addr;
    logic [23:0] wdata;
    logic [23:0] rdata;
    logic        done;
  } port_t;
  port_t st, next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (!st.busy && mif.req && !st.done) begin
      next_st.busy  = 1'b1;
      next_st.we    = mif.we;
      next_st.addr  = mif.addr;
      next_st.wdata = mif.wdata;
    end else if (st.busy && memAck) begin
      next_st.busy  = 1'b0;
      next_st.rdata = memRdata;
      next_st.done  = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign memReq    = st.busy;
  assign memWe     = st.we;
  assign memAddr   = st.addr;
  assign memWdata  = st.wdata;
  assign mif.rdata = st.rdata;
  assign mif.done  = st.done;
endmodule // lssu_mem_port
`default_nettype wire

// ===== hdl/lssu_pkg.sv
`default_nettype none
package lssu_pkg;
  // ----------------------------------------------------------------------
  // Instruction word layout
  // ----------------------------------------------------------------------
  localparam int OPC_HI    = 23;
  localparam int OPC_LO    = 18;
  localparam int AMODE_BIT = 17;
  localparam int IDX_HI    = 16;
  localparam int IDX_LO    = 15;
  localparam int ADDR_HI   = 14;
  localparam int SIGN_BIT  = 23;
  // ----------------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------------
  localparam logic [5:0] OP_LOAD_ACC       = 6'h10;
  localparam logic [5:0] OP_LOAD_AUX       = 6'h11;
  localparam logic [5:0] OP_LOAD_ACC_CHAR  = 6'h12;
  localparam logic [5:0] OP_LOAD_AUX_CHAR  = 6'h13;
  localparam logic [5:0] OP_LOAD_ACC_COMP  = 6'h14;
  localparam logic [5:0] OP_LOAD_PAIR      = 6'h15;
  localparam logic [5:0] OP_LOAD_PAIR_COMP = 6'h16;
  localparam logic [5:0] OP_LOAD_LOGICAL   = 6'h17;
  localparam logic [5:0] OP_LOAD_INDEX     = 6'h2C;
  localparam logic [5:0] OP_STORE_ACC      = 6'h20;
  localparam logic [5:0] OP_STORE_AUX      = 6'h21;
  localparam logic [5:0] OP_STORE_ACC_CHAR = 6'h22;
  localparam logic [5:0] OP_STORE_AUX_CHAR = 6'h23;
  localparam logic [5:0] OP_STORE_WORD_ADR = 6'h24;
  localparam logic [5:0] OP_STORE_PAIR     = 6'h25;
  localparam logic [5:0] OP_STORE_CHAR_ADR = 6'h26;
  localparam logic [5:0] OP_STORE_INDEX    = 6'h27;
  localparam logic [5:0] OP_SENSE_ROTATE   = 6'h08;
  localparam logic [5:0] OP_SHIFT_REG      = 6'h0A;
  // ----------------------------------------------------------------------
  // Reset values and field sizes
  // ----------------------------------------------------------------------
  localparam logic [23:0] WORD_RESET  = 24'h000000;
  localparam logic [14:0] INDEX_RESET = 15'h0000;
  localparam int CHAR_W   = 6;
  localparam int WADDR_W  = 15;
  localparam int CADDR_W  = 17;
  localparam int SHAMT_W  = 6;
  localparam int WORD_W   = 24;
  localparam int RIGHT_FILL_COUNT = 23;
endpackage
`default_nettype wire

// ===== sim/core_store_model.sv
`default_nettype none
// ----------------------------------------------------------------------
// Core storage with adjustable answer delay
// ----------------------------------------------------------------------
module core_store_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Storage pins
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [14:0] memAddr,
  input  wire logic [23:0] memWdata,
  output logic [23:0]      memRdata,
  output logic             memAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] mem [0:32767];
  int          lag = 0;
  int          cnt = 0;
  initial begin
    memAck = 1'b0;
    memRdata = 24'h000000;
  end
  // Data toggles off the answer cycle so a sample one cycle late never matches
  always @(posedge clock) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (srst) begin
      cnt <= 0;
    end else if (memReq && !memAck) begin
      if (cnt < lag) begin
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
        memAck <= 1'b1;
        if (memWe) mem[memAddr] <= memWdata;
        else memRdata <= mem[memAddr];
      end
    end
  end
endmodule // core_store_model
`default_nettype wire

// ===== sim/load_store_shift_unit_tb.sv
`default_nettype none
module load_store_shift_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  logic [23:0] instr = 24'h000000;
  logic        busy, done, skip, illegal, memReq, memWe, memAck;
  logic [23:0] acc, aux, memWdata, memRdata;
  logic [14:0] index1, index2, index3, memAddr;
  logic        sk, il;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  load_store_shift_unit u_dut (.clock, .srst, .start, .instr, .busy, .done, .skip,
    .illegal, .acc, .aux, .index1, .index2, .index3, .memReq, .memWe, .memAddr,
    .memWdata, .memRdata, .memAck);
  core_store_model u_mem (.clock, .srst, .memReq, .memWe, .memAddr, .memWdata,
    .memRdata, .memAck);
  initial begin
    forever #20 clock = ~clock;
  end
  // Whole run needs about 300 cycles; the ceiling leaves wide margin
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [23:0] ins(input logic [5:0] op, input logic [17:0] f);
    return {op, f};
  endfunction
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic ex(input logic [23:0] i);
    int n;
    @(posedge clock);
    start <= 1'b1;
    instr <= i;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    chk({23'h0, busy}, 24'h000001);
    for (n = 0; n < 100 && done !== 1'b1; n++) @(negedge clock);
    chk({23'h0, done}, 24'h000001);
    sk = skip;
    il = illegal;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_load();
    u_mem.mem[15'h064] = 24'hA5C3F0;
    u_mem.mem[15'h065] = 24'h123456;
    ex(ins(lssu_pkg::OP_LOAD_ACC, 18'h00064));
    chk(acc, 24'hA5C3F0);
    ex(ins(lssu_pkg::OP_LOAD_AUX, 18'h00065));
    chk(aux, 24'h123456);
    ex(ins(lssu_pkg::OP_LOAD_LOGICAL, 18'h00064));
    chk(acc, 24'h123456 & 24'hA5C3F0);
    ex(ins(lssu_pkg::OP_LOAD_ACC_COMP, 18'h00065));
    chk(acc, ~24'h123456);
    $display("t_load finished");
  endtask
  task automatic t_pair();
    u_mem.lag = 3;
    u_mem.mem[15'h7FFE] = 24'h111111;
    u_mem.mem[15'h7FFF] = 24'h222222;
    u_mem.mem[15'h0001] = 24'h333333;
    ex(ins(lssu_pkg::OP_LOAD_PAIR, 18'h07FFE));
    chk(acc, 24'h111111);
    chk(aux, 24'h222222);
    ex(ins(lssu_pkg::OP_LOAD_PAIR_COMP, 18'h07FFF));
    chk(acc, 24'hDDDDDD);
    chk(aux, 24'hCCCCCC);
    ex(ins(lssu_pkg::OP_STORE_PAIR, 18'h000C8));
    chk(u_mem.mem[15'h0C8], 24'hDDDDDD);
    chk(u_mem.mem[15'h0C9], 24'hCCCCCC);
    chk(acc, 24'hDDDDDD);
    u_mem.mem[15'h0001] = 24'h000000;
    ex(ins(lssu_pkg::OP_STORE_PAIR, 18'h07FFF));
    chk(u_mem.mem[15'h0001], 24'hCCCCCC);
    $display("t_pair finished");
  endtask
  task automatic t_store();
    u_mem.lag = 0;
    u_mem.mem[15'h066] = 24'h3C0000;
    u_mem.mem[15'h067] = 24'h3C0000;
    u_mem.mem[15'h068] = 24'hFFFFFF;
    u_mem.mem[15'h069] = 24'h008064;
    ex(ins(lssu_pkg::OP_STORE_ACC, 18'h0012C));
    chk(u_mem.mem[15'h12C], 24'hDDDDDD);
    ex(ins(lssu_pkg::OP_STORE_AUX, 18'h0012D));
    chk(u_mem.mem[15'h12D], 24'hCCCCCC);
    chk(aux, 24'hCCCCCC);
    ex(ins(lssu_pkg::OP_STORE_WORD_ADR, 18'h00066));
    chk(u_mem.mem[15'h066], 24'h3C5DDD);
    ex(ins(lssu_pkg::OP_STORE_CHAR_ADR, 18'h00067));
    chk(u_mem.mem[15'h067], 24'h3DDDDD);
    chk(acc, 24'hDDDDDD);
    ex(ins(lssu_pkg::OP_LOAD_INDEX, 18'h08065));
    chk({9'h000, index1}, 24'h003456);
    ex(ins(lssu_pkg::OP_LOAD_INDEX, 18'h10064));
    chk({9'h000, index2}, 24'h0043F0);
    ex(ins(lssu_pkg::OP_LOAD_INDEX, 18'h38069));
    chk({9'h000, index3}, 24'h0043F0);
    ex(ins(lssu_pkg::OP_STORE_INDEX, 18'h08068));
    chk(u_mem.mem[15'h068], 24'hFFB456);
    chk({9'h000, index1}, 24'h003456);
    $display("t_store finished");
  endtask
  task automatic t_char();
    u_mem.lag = 1;
    u_mem.mem[15'h190] = 24'h123456;
    ex(ins(lssu_pkg::OP_LOAD_ACC_CHAR, 18'h00641));
    chk(acc, 24'h000023);
    ex(ins(lssu_pkg::OP_LOAD_AUX_CHAR, 18'h00643));
    chk(aux, 24'h000016);
    ex(ins(lssu_pkg::OP_STORE_ACC_CHAR, 18'h00640));
    chk(u_mem.mem[15'h190], {6'h23, 18'h23456});
    ex(ins(lssu_pkg::OP_STORE_AUX_CHAR, 18'h00642));
    chk(u_mem.mem[15'h190], {6'h23, 6'h23, 6'h16, 6'h16});
    chk(acc, 24'h000023);
    // Index two is negative here, so only a sign-extended add reaches this word
    u_mem.mem[15'h1190] = 24'hABCDEF;
    ex(ins(lssu_pkg::OP_STORE_ACC_CHAR, 18'h08250));
    chk(u_mem.mem[15'h1190], {6'h23, 18'h3CDEF});
    $display("t_char finished");
  endtask
  task automatic t_sense_shift();
    u_mem.lag = 2;
    u_mem.mem[15'h1F4] = 24'h800001;
    u_mem.mem[15'h1F5] = 24'h800003;
    ex(ins(lssu_pkg::OP_SENSE_ROTATE, 18'h001F4));
    chk({23'h0, sk}, 24'h000001);
    chk(u_mem.mem[15'h1F4], 24'h000003);
    ex(ins(lssu_pkg::OP_SENSE_ROTATE, 18'h001F4));
    chk({23'h0, sk}, 24'h000000);
    chk(u_mem.mem[15'h1F4], 24'h000006);
    ex(ins(lssu_pkg::OP_LOAD_ACC, 18'h001F5));
    ex(ins(lssu_pkg::OP_SHIFT_REG, 18'h00003));
    chk(acc, 24'h00001C);
    ex(ins(lssu_pkg::OP_SHIFT_REG, 18'h00018));
    chk(acc, 24'h00001C);
    ex(ins(lssu_pkg::OP_LOAD_ACC, 18'h001F5));
    ex(ins(lssu_pkg::OP_SHIFT_REG, 18'h07FFC));
    chk(acc, 24'hF00000);
    ex(ins(lssu_pkg::OP_SHIFT_REG, 18'h07FE1));
    chk(acc, 24'hFFFFFF);
    ex(ins(lssu_pkg::OP_SHIFT_REG, 18'h28000));
    chk(aux, 24'h800005);
    ex(ins(6'h3F, 18'h00000));
    chk({23'h0, il}, 24'h000001);
    chk(acc, 24'hFFFFFF);
    $display("t_sense_shift finished");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    chk(acc, 24'h000000);
    t_load();
    t_pair();
    t_store();
    t_char();
    t_sense_shift();
    final_report();
  end
endmodule // load_store_shift_unit_tb
`default_nettype wire
